// ===== verilog/power_monitor_status_reporting.sv
// status reporting bank: latched status bytes, summary word, alert
//
// What this block does
// - turn-on timeout sets flags, action, alert
// - summary read returns two-byte condensed word
// - bit 15 on any voltage condition
// - bit 14 on overcurrent fault or warning
// - bit 12 on any global vendor byte bit
// - bit 11 ORs per-channel power-good-lost bits
// - bit 8 on any margining fault
// - bit 6 ORs per-channel sequenced-off bits
// - bits 5/4 on overvoltage/overcurrent faults only
// - bit 2 temperature, bit 1 comm/memory/logic
// - unassigned bits always read zero
// - sequenced-off and power-good-lost never alert
// - voltage byte holds five latched flags
// - level flags re-set while condition persists
// - current byte: bit 7 fault, 5 warning
// - temperature byte: bit 7 fault, 6 warning
// - bad command/data flags latch per occurrence
// - array corrupt flags latch, never alert
// - log-full bit unlatched without wrap, follows log state
// - wrap mode: log-full clears on overwrite
// - sequenced-off: enabled channel, enable low
`timescale 1ns/1ns
`include "pm_status_params.svh"

module power_monitor_status_reporting (
	input  wire logic                           clk,
	input  wire logic                           rst_n,
	input  wire pm_status_pkg::host_cmd_s       hostCmd,
	input  wire pm_status_pkg::voltage_summary_bit_cond_s      voutCond,
	input  wire pm_status_pkg::current_summary_bit_temp_cond_s ioutTempCond,
	input  wire pm_status_pkg::cml_cond_s       cmlCond,
	input  wire pm_status_pkg::seq_cond_s       seqCond,
	input  wire logic [7:0]                     vendorSpecificStatus,
	input  wire logic                           alertEnable,
	input  wire logic                           eventLogWrapEnable,
	output logic      [15:0]                    readData,
	output logic                                readValid,
	output logic                                readHit,
	output logic                                alertOut,
	output logic                                faultActionReq
);

	// ************************************************
	// condition shaping
	// ************************************************

	logic [7:0]  voutSet;
	logic [7:0]  ioutSet;
	logic [7:0]  tempSet;
	logic [7:0]  cmlSet;
	logic        marginSet;
	logic [`PM_SEQ_CHANNELS-1:0] seqOffBits;
	logic        clearFaults;
	logic        turnOnEvent;

	// a clear is its own strobe bit on the host port, not a decoded command code
	assign clearFaults = hostCmd.clearFaults;

	// either time limit counts as a turn-on timeout event
	assign turnOnEvent = |voutCond.turnOnLimitEvent
		| |voutCond.seqTurnOnMaxEvent;

	// voltage set terms: levels re-set, timeout only on a new event
	always_comb begin
		voutSet = `PM_RESET_BYTE;
		voutSet[`PM_VO_OV_FAULT]    = |voutCond.overvoltageFault;
		voutSet[`PM_VO_OV_WARN]     = |voutCond.overvoltageWarning;
		voutSet[`PM_VO_UV_WARN]     = |voutCond.undervoltageWarning;
		voutSet[`PM_VO_UV_FAULT]    = |voutCond.undervoltageFault;
		voutSet[`PM_VO_TON_TIMEOUT] = turnOnEvent;
	end

	// current set terms, both level driven
	always_comb begin
		ioutSet = `PM_RESET_BYTE;
		ioutSet[`PM_IO_OC_FAULT] = |ioutTempCond.overcurrentFault;
		ioutSet[`PM_IO_OC_WARN]  = |ioutTempCond.overcurrentWarning;
	end

	// temperature set terms over all sensors
	always_comb begin
		tempSet = `PM_RESET_BYTE;
		tempSet[`PM_TE_OVERTEMPERATURE_FAULT] = |ioutTempCond.overtemperatureFault;
		tempSet[`PM_TE_OVERTEMPERATURE_WARNING]  = |ioutTempCond.overtemperatureWarning;
	end

	// comm and memory events are pulses, so they re-set only on recurrence
	always_comb begin
		cmlSet = `PM_RESET_BYTE;
		cmlSet[`PM_CM_BAD_CMD]  = cmlCond.badCommand;
		cmlSet[`PM_CM_BAD_DATA] = cmlCond.badData;
		cmlSet[`PM_CM_BACKUP]   = cmlCond.secondaryArrayCorrupt;
		cmlSet[`PM_CM_MAIN]     = cmlCond.mainArrayCorrupt;
	end

	assign marginSet = |seqCond.marginFault;

	// sequenced-off per channel; a disabled channel always reads clear
	genvar ch;
	generate
		for (ch = 0; ch < `PM_SEQ_CHANNELS; ch++) begin : g_seqoff
			assign seqOffBits[ch] = seqCond.channelEnabled[ch]
				& ~seqCond.supplyEnableOutput[ch];
		end
	endgenerate

	// ************************************************
	// latched flag banks
	// ************************************************

	logic [7:0] voutFlags;
	logic [7:0] ioutFlags;
	logic [7:0] tempFlags;
	logic [7:0] cmlFlags;
	logic [0:0] marginFlag;

	// one bank per category; all share the clear-faults strobe
	status_flag_latch #(.WIDTH(8)) u_voltage_summary_bit (
		.clk      (clk),
		.rst_n    (rst_n),
		.setIn    (voutSet),
		.clearAll (clearFaults),
		.flags    (voutFlags)
	);

	status_flag_latch #(.WIDTH(8)) u_current_summary_bit (
		.clk      (clk),
		.rst_n    (rst_n),
		.setIn    (ioutSet),
		.clearAll (clearFaults),
		.flags    (ioutFlags)
	);

	status_flag_latch #(.WIDTH(8)) u_temp (
		.clk      (clk),
		.rst_n    (rst_n),
		.setIn    (tempSet),
		.clearAll (clearFaults),
		.flags    (tempFlags)
	);

	status_flag_latch #(.WIDTH(8)) u_cml (
		.clk      (clk),
		.rst_n    (rst_n),
		.setIn    (cmlSet),
		.clearAll (clearFaults),
		.flags    (cmlFlags)
	);

	status_flag_latch #(.WIDTH(1)) u_margin (
		.clk      (clk),
		.rst_n    (rst_n),
		.setIn    (marginSet),
		.clearAll (clearFaults),
		.flags    (marginFlag)
	);

	// ************************************************
	// event log full indication
	// ************************************************

	logic logFullPrev_reg;
	logic wrapFull_reg;
	logic wrapFull_next;
	logic logFullBit;

	// edge memory of the log-full level
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			logFullPrev_reg <= 1'b0;
		end else begin
			logFullPrev_reg <= cmlCond.logFull;
		end
	end

	// in wrap mode the first overwrite frees two entries, so the log is no longer full
	always_comb begin
		wrapFull_next = wrapFull_reg;
		if (cmlCond.logFull && !logFullPrev_reg) begin
			wrapFull_next = 1'b1;
		end
		if (cmlCond.logOverwrite) begin
			wrapFull_next = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrapFull_reg <= 1'b0;
		end else begin
			wrapFull_reg <= wrapFull_next;
		end
	end

	// untouched by clear-faults; latched only in wrap mode, otherwise it shows the log as it is
	assign logFullBit = (eventLogWrapEnable == `PM_WRAP_ON) ?
		wrapFull_reg : cmlCond.logFull;

	// ************************************************
	// status byte and summary word images
	// ************************************************

	logic [7:0]  cmlImage;
	logic [15:0] summaryWord;

	always_comb begin
		cmlImage = cmlFlags;
		cmlImage[`PM_CM_LOG_FULL] = logFullBit;
	end

	// summary condenses the latched bytes and clears with them; vendor, power-good-lost and sequenced-off bits are live
	always_comb begin
		summaryWord = `PM_RESET_WORD;
		summaryWord[`PM_SW_VOLTAGE_SUMMARY_BIT]    = |voutFlags;
		summaryWord[`PM_SW_CURRENT_SUMMARY_BIT]    = |ioutFlags;
		summaryWord[`PM_SW_VENDOR]  = |vendorSpecificStatus;
		summaryWord[`PM_SW_PG_LOST] = |seqCond.powerGoodLost;
		summaryWord[`PM_SW_MARGIN]  = marginFlag[0];
		summaryWord[`PM_SW_SEQ_OFF] = |seqOffBits;
		summaryWord[`PM_SW_OV]      = voutFlags[`PM_VO_OV_FAULT];
		summaryWord[`PM_SW_OC]      = ioutFlags[`PM_IO_OC_FAULT];
		summaryWord[`PM_SW_TEMP]    = |tempFlags;
		summaryWord[`PM_SW_CML]     = |cmlImage;
	end

	// ************************************************
	// host read port
	// ************************************************

	pm_status_pkg::answer_state_e ansState_reg;
	logic [15:0] readData_reg;
	logic        readHit_reg;
	logic [15:0] readData_next;
	logic        readHit_next;

	// decode of the status commands; byte registers sit in the low bits
	always_comb begin
		readData_next = `PM_RESET_WORD;
		readHit_next  = 1'b1;
		unique case (hostCmd.commandCode)
			`PM_CMD_SUMMARY: begin
				readData_next = summaryWord;
			end
			`PM_CMD_VOLTAGE_SUMMARY_BIT: begin
				readData_next = {8'h00, voutFlags};
			end
			`PM_CMD_CURRENT_SUMMARY_BIT: begin
				readData_next = {8'h00, ioutFlags};
			end
			`PM_CMD_TEMP: begin
				readData_next = {8'h00, tempFlags};
			end
			`PM_CMD_CML: begin
				readData_next = {8'h00, cmlImage};
			end
			default: begin
				readHit_next = 1'b0; // other commands belong to other banks
			end
		endcase
	end

	// answer state: valid in the cycle after each strobed cycle, so one cycle for a one-cycle strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ansState_reg <= pm_status_pkg::ANS_IDLE;
		end else begin
			unique case (ansState_reg)
				pm_status_pkg::ANS_IDLE: begin
					if (hostCmd.readStrobe) begin
						ansState_reg <= pm_status_pkg::ANS_VALID;
					end
				end
				pm_status_pkg::ANS_VALID: begin
					if (!hostCmd.readStrobe) begin
						ansState_reg <= pm_status_pkg::ANS_IDLE;
					end
				end
				default: begin
					ansState_reg <= pm_status_pkg::ANS_IDLE;
				end
			endcase
		end
	end

	// data captured with the strobe and held until the next read
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readData_reg <= `PM_RESET_WORD;
			readHit_reg  <= 1'b0;
		end else if (hostCmd.readStrobe) begin
			readData_reg <= readData_next;
			readHit_reg  <= readHit_next;
		end
	end

	assign readData  = readData_reg;
	assign readHit   = readHit_reg;
	// one-hot code: the valid state bit is the flag itself, straight from its flip-flop
	assign readValid = ansState_reg[1];

	// ************************************************
	// alert and fault action
	// ************************************************

	logic alert_reg;
	logic faultAction_reg;
	logic alertCause;
	logic actionCause;

	// alert causes omit sequenced-off, power-good-lost, array corrupt and log full
	assign alertCause = |voutFlags | |ioutFlags | |tempFlags
		| cmlFlags[`PM_CM_BAD_CMD] | cmlFlags[`PM_CM_BAD_DATA]
		| marginFlag[0];

	// faults that call for the configured response, warnings excluded
	assign actionCause = turnOnEvent
		| voutSet[`PM_VO_OV_FAULT] | voutSet[`PM_VO_UV_FAULT]
		| ioutSet[`PM_IO_OC_FAULT] | tempSet[`PM_TE_OVERTEMPERATURE_FAULT];

	// alert stays up while any alerting flag is latched and alerts are enabled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			alert_reg <= 1'b0;
		end else begin
			alert_reg <= alertEnable & alertCause;
		end
	end

	// level request to the response logic, one cycle behind its cause
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			faultAction_reg <= 1'b0;
		end else begin
			faultAction_reg <= actionCause;
		end
	end

	assign alertOut       = alert_reg;
	assign faultActionReq = faultAction_reg;

endmodule

// ===== inc/pm_status_params.svh
// constants of the power monitor status reporting bank
`ifndef PM_STATUS_PARAMS_SVH
`define PM_STATUS_PARAMS_SVH

// ************************************************
// channel counts
// ************************************************
`define PM_MON_CHANNELS     16
`define PM_SEQ_CHANNELS     12
`define PM_TEMP_SENSORS     5

// ************************************************
// command codes of the status registers
// ************************************************
`define PM_CMD_CLEAR_FAULTS 8'h03
`define PM_CMD_SUMMARY      8'h79
`define PM_CMD_VOLTAGE_SUMMARY_BIT         8'h7a
`define PM_CMD_CURRENT_SUMMARY_BIT         8'h7b
`define PM_CMD_TEMP         8'h7d
`define PM_CMD_CML          8'h7e

// ************************************************
// summary word bit positions
// ************************************************
`define PM_SW_VOLTAGE_SUMMARY_BIT          15
`define PM_SW_CURRENT_SUMMARY_BIT          14
`define PM_SW_VENDOR        12
`define PM_SW_PG_LOST       11
`define PM_SW_MARGIN        8
`define PM_SW_SEQ_OFF       6
`define PM_SW_OV            5
`define PM_SW_OC            4
`define PM_SW_TEMP          2
`define PM_SW_CML           1

// ************************************************
// status byte bit positions
// ************************************************
`define PM_VO_OV_FAULT      7
`define PM_VO_OV_WARN       6
`define PM_VO_UV_WARN       5
`define PM_VO_UV_FAULT      4
`define PM_VO_TON_TIMEOUT   2
`define PM_IO_OC_FAULT      7
`define PM_IO_OC_WARN       5
`define PM_TE_OVERTEMPERATURE_FAULT      7
`define PM_TE_OVERTEMPERATURE_WARNING       6
`define PM_CM_BAD_CMD       7
`define PM_CM_BAD_DATA      6
`define PM_CM_BACKUP        2
`define PM_CM_MAIN          1
`define PM_CM_LOG_FULL      0

// ************************************************
// reset values
// ************************************************
`define PM_RESET_BYTE       8'h00
`define PM_RESET_WORD       16'h0000
`define PM_WRAP_ON          1'b1

`endif

// ===== inc/pm_status_pkg.sv
// types of the power monitor status reporting bank
`include "pm_status_params.svh"

package pm_status_pkg;

	// voltage conditions per monitored channel, turn-on timeouts per sequenced channel
	typedef struct packed {
		logic [`PM_MON_CHANNELS-1:0] overvoltageFault;
		logic [`PM_MON_CHANNELS-1:0] overvoltageWarning;
		logic [`PM_MON_CHANNELS-1:0] undervoltageWarning;
		logic [`PM_MON_CHANNELS-1:0] undervoltageFault;
		logic [`PM_SEQ_CHANNELS-1:0] turnOnLimitEvent;
		logic [`PM_SEQ_CHANNELS-1:0] seqTurnOnMaxEvent;
	} voltage_summary_bit_cond_s;

	// current and temperature conditions
	typedef struct packed {
		logic [`PM_MON_CHANNELS-1:0] overcurrentFault;
		logic [`PM_MON_CHANNELS-1:0] overcurrentWarning;
		logic [`PM_TEMP_SENSORS-1:0] overtemperatureFault;
		logic [`PM_TEMP_SENSORS-1:0] overtemperatureWarning;
	} current_summary_bit_temp_cond_s;

	// communication, memory and log events
	typedef struct packed {
		logic badCommand;
		logic badData;
		logic secondaryArrayCorrupt;
		logic mainArrayCorrupt;
		logic logFull;
		logic logOverwrite;
	} cml_cond_s;

	// per sequenced channel state
	typedef struct packed {
		logic [`PM_SEQ_CHANNELS-1:0] channelEnabled;
		logic [`PM_SEQ_CHANNELS-1:0] supplyEnableOutput;
		logic [`PM_SEQ_CHANNELS-1:0] powerGoodLost;
		logic [`PM_SEQ_CHANNELS-1:0] marginFault;
	} seq_cond_s;

	// host command port
	typedef struct packed {
		logic       readStrobe;
		logic       clearFaults;
		logic [7:0] commandCode;
	} host_cmd_s;

	// answer state of the read port
	typedef enum logic [1:0] {
		ANS_IDLE  = 2'b01,
		ANS_VALID = 2'b10
	} answer_state_e;

endpackage

// ===== verilog/status_flag_latch.sv
// sticky flag bank, set wins over clear
`timescale 1ns/1ns

module status_flag_latch #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] setIn,
	input  wire logic             clearAll,
	output logic      [WIDTH-1:0] flags
);

	logic [WIDTH-1:0] flags_reg;

	// a set in the clear cycle survives, so no event is lost
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flags_reg <= '0;
		end else if (clearAll) begin
			flags_reg <= setIn;
		end else begin
			flags_reg <= flags_reg | setIn;
		end
	end

	assign flags = flags_reg;

endmodule

// ===== test/power_monitor_status_reporting_checker.sv
// assertion checker for the status reporting bank
`timescale 1ns/1ns

module power_monitor_status_reporting_checker (
	input wire logic                           clk,
	input wire logic                           rst_n,
	input wire pm_status_pkg::host_cmd_s       hostCmd,
	input wire pm_status_pkg::voltage_summary_bit_cond_s      voutCond,
	input wire pm_status_pkg::current_summary_bit_temp_cond_s ioutTempCond,
	input wire pm_status_pkg::cml_cond_s       cmlCond,
	input wire pm_status_pkg::seq_cond_s       seqCond,
	input wire logic [7:0]                     vendorSpecificStatus,
	input wire logic                           alertEnable,
	input wire logic                           eventLogWrapEnable,
	input wire logic [15:0]                    readData,
	input wire logic                           readValid,
	input wire logic                           readHit,
	input wire logic                           alertOut,
	input wire logic                           faultActionReq
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ************************************************
	// read decode helpers
	// ************************************************
	logic rdSum;
	logic rdVout;
	logic rdCml;

	// plain decodes, so each read-data property keys on one name
	assign rdSum = hostCmd.readStrobe && hostCmd.commandCode == 8'h79;
	assign rdVout = hostCmd.readStrobe && hostCmd.commandCode == 8'h7a;
	assign rdCml = hostCmd.readStrobe && hostCmd.commandCode == 8'h7e;

	sequence tonEvent;
		|voutCond.turnOnLimitEvent;
	endsequence

	sequence ovSeen;
		$past(|voutCond.overvoltageFault) && $past(rst_n) ##0 rdSum;
	endsequence

	chk_valid_after_read: assert property (hostCmd.readStrobe |=> readValid)
		else $error("no answer after read strobe");
	chk_ov_summary: assert property (ovSeen |=> readData[15] && readData[5])
		else $error("overvoltage missing in summary");
	chk_sum_reserved: assert property (rdSum |=> (readData & 16'h2689) == 16'h0000)
		else $error("reserved summary bit set");
	chk_voltage_summary_bit_reserved: assert property (rdVout |=> (readData & 16'hff0b) == 16'h0000)
		else $error("reserved voltage bit set");
	chk_pg_live: assert property (rdSum |=> readData[11] == $past(|seqCond.powerGoodLost))
		else $error("power good lost summary wrong");
	chk_seqoff_live: assert property (rdSum |=> readData[6] ==
		$past(|(seqCond.channelEnabled & ~seqCond.supplyEnableOutput)))
		else $error("sequenced off summary wrong");
	chk_vendor_live: assert property (rdSum |=> readData[12] == $past(|vendorSpecificStatus))
		else $error("vendor summary wrong");
	chk_log_follow: assert property (rdCml && !eventLogWrapEnable |=>
		readData[0] == $past(cmlCond.logFull))
		else $error("log full bit not live");
	chk_alert_gated: assert property (!$past(alertEnable) |-> !alertOut)
		else $error("alert while alerts disabled");
	chk_ton_action: assert property (tonEvent |=> faultActionReq)
		else $error("no fault action after timeout");
endmodule

bind power_monitor_status_reporting power_monitor_status_reporting_checker u_chk (
	.clk(clk), .rst_n(rst_n), .hostCmd(hostCmd), .voutCond(voutCond),
	.ioutTempCond(ioutTempCond), .cmlCond(cmlCond), .seqCond(seqCond),
	.vendorSpecificStatus(vendorSpecificStatus), .alertEnable(alertEnable),
	.eventLogWrapEnable(eventLogWrapEnable), .readData(readData), .readValid(readValid),
	.readHit(readHit), .alertOut(alertOut), .faultActionReq(faultActionReq));

// ===== test/status_host_model.sv
// host-side model issuing status reads and clear-faults
`timescale 1ns/1ns

module status_host_model (
	input  wire logic                clk,
	output pm_status_pkg::host_cmd_s hostCmd
);
	// idle command code is the inverse of the last, so stale codes never pass as valid
	initial begin
		hostCmd = '0;
	end

	// one-cycle read strobe; answer is taken at the edge raising readValid
	task automatic send_read(input logic [7:0] code);
		@(negedge clk);
		hostCmd.readStrobe = 1'b1;
		hostCmd.commandCode = code;
		@(negedge clk);
		hostCmd.readStrobe = 1'b0;
		hostCmd.commandCode = ~code;
	endtask

	// one-cycle clear-faults pulse
	task automatic send_clear();
		@(negedge clk);
		hostCmd.clearFaults = 1'b1;
		@(negedge clk);
		hostCmd.clearFaults = 1'b0;
	endtask
endmodule

// ===== test/tb_top.sv
// self-checking bench of the status reporting bank
`timescale 1ns/1ns

module tb_top;
	logic                           clk;
	logic                           rst_n;
	pm_status_pkg::host_cmd_s       hostCmd;
	pm_status_pkg::voltage_summary_bit_cond_s      vc;
	pm_status_pkg::current_summary_bit_temp_cond_s it;
	pm_status_pkg::cml_cond_s       cc;
	pm_status_pkg::seq_cond_s       sc;
	logic [7:0]                     vendor;
	logic                           alertEn;
	logic                           wrapEn;
	logic [15:0]                    readData;
	logic                           readValid;
	logic                           readHit;
	logic                           alertOut;
	logic                           faultAct;
	int                             error_cnt;
	int                             total_checks;
	int                             cycles;
	// per case: code read, its answer, summary, alert (2 = not judged), pulse
	logic [7:0]  codeT [18] = '{8'h7a, 8'h7a, 8'h7a, 8'h7a, 8'h7a, 8'h7a, 8'h7b, 8'h7b,
		8'h7d, 8'h7d, 8'h7e, 8'h7e, 8'h7e, 8'h7e, 8'h79, 8'h79, 8'h79, 8'h79};
	logic [15:0] ansT [18] = '{16'h0080, 16'h0040, 16'h0020, 16'h0010, 16'h0004, 16'h0004,
		16'h0080, 16'h0020, 16'h0080, 16'h0040, 16'h0080, 16'h0040, 16'h0004, 16'h0002,
		16'h0800, 16'h0040, 16'h1000, 16'h0100};
	logic [15:0] sumT [18] = '{16'h8020, 16'h8000, 16'h8000, 16'h8000, 16'h8000, 16'h8000,
		16'h4010, 16'h4000, 16'h0004, 16'h0004, 16'h0002, 16'h0002, 16'h0002, 16'h0002,
		16'h0800, 16'h0040, 16'h1000, 16'h0100};
	int          alertT [18] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 2};
	int          pulseT [18] = '{0, 0, 0, 0, 1, 1, 0, 0, 0, 0, 1, 1, 1, 1, 0, 0, 0, 0};

	status_host_model u_host (.clk(clk), .hostCmd(hostCmd));

	power_monitor_status_reporting u_dut (
		.clk(clk), .rst_n(rst_n), .hostCmd(hostCmd), .voutCond(vc), .ioutTempCond(it),
		.cmlCond(cc), .seqCond(sc), .vendorSpecificStatus(vendor), .alertEnable(alertEn),
		.eventLogWrapEnable(wrapEn), .readData(readData), .readValid(readValid),
		.readHit(readHit), .alertOut(alertOut), .faultActionReq(faultAct));

	// ************************************************
	// helpers
	// ************************************************
	task automatic drive(input int i, input logic v);
		case (i)
			0: vc.overvoltageFault[2] = v;
			1: vc.overvoltageWarning[9] = v;
			2: vc.undervoltageWarning[0] = v;
			3: vc.undervoltageFault[15] = v;
			4: vc.turnOnLimitEvent[1] = v;
			5: vc.seqTurnOnMaxEvent[11] = v;
			6: it.overcurrentFault[15] = v;
			7: it.overcurrentWarning[3] = v;
			8: it.overtemperatureFault[4] = v;
			9: it.overtemperatureWarning[0] = v;
			10: cc.badCommand = v;
			11: cc.badData = v;
			12: cc.secondaryArrayCorrupt = v;
			13: cc.mainArrayCorrupt = v;
			14: sc.powerGoodLost[5] = v;
			15: begin
				sc.channelEnabled[7] = v;
				sc.supplyEnableOutput[7] = ~v; // enabled channel held off by the sequencer
			end
			16: vendor[3] = v;
			default: sc.marginFault[0] = v;
		endcase
	endtask

	// an unmapped code must miss, all others hit
	task automatic read_check(input logic [7:0] code, input logic [15:0] exp);
		u_host.send_read(code);
		total_checks++;
		if (readValid !== 1'b1 || readData !== exp || readHit !== (code != 8'h7c)) begin
			error_cnt++;
			$display("[FAIL] %0t read %h got %h want %h", $time, code, readData, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t flag got %b want %b", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// free-running clock, 20 ns period
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		rst_n = 1'b0;
		vc = '0;
		it = '0;
		cc = '0;
		sc = '0;
		sc.supplyEnableOutput = '1;
		vendor = 8'h00;
		alertEn = 1'b1;
		wrapEn = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		foreach (codeT[k]) read_check(k < 6 ? codeT[k * 3] : 8'h7c, 16'h0000);
		for (int i = 0; i < 18; i++) begin
			drive(i, 1'b1);
			if (pulseT[i] != 0) begin
				@(negedge clk);
				drive(i, 1'b0);
			end
			repeat (2) @(negedge clk);
			read_check(codeT[i], ansT[i]);
			read_check(8'h79, sumT[i]);
			if (alertT[i] != 2) check_bit(alertOut, alertT[i][0]);
			drive(i, 1'b0);
			u_host.send_clear();
			read_check(codeT[i], 16'h0000);
		end
		// a held overcurrent comes straight back after a clear
		it.overcurrentFault[0] = 1'b1;
		u_host.send_clear();
		read_check(8'h7b, 16'h0080);
		it.overcurrentFault[0] = 1'b0;
		u_host.send_clear();
		read_check(8'h7b, 16'h0000);
		// log full: live without wrap, cleared by overwrite with wrap
		cc.logFull = 1'b1;
		u_host.send_clear();
		read_check(8'h7e, 16'h0001);
		cc.logFull = 1'b0;
		read_check(8'h7e, 16'h0000);
		wrapEn = 1'b1;
		cc.logFull = 1'b1;
		read_check(8'h7e, 16'h0001);
		cc.logOverwrite = 1'b1;
		@(negedge clk);
		cc.logOverwrite = 1'b0;
		read_check(8'h7e, 16'h0000);
		cc.logFull = 1'b0;
		wrapEn = 1'b0;
		// alerts off: fault acts but stays silent
		alertEn = 1'b0;
		vc.overvoltageFault[0] = 1'b1;
		repeat (3) @(negedge clk);
		check_bit(alertOut, 1'b0);
		check_bit(faultAct, 1'b1);
		vc.overvoltageFault[0] = 1'b0;
		u_host.send_clear();
		read_check(8'h79, 16'h0000);
		report_and_stop();
	end
endmodule
